// ==== verilog/sar_adc_seq.sv ====
`timescale 1ns/10ps
`default_nettype none
module sar_adc_seq
  import sar_pkg::*;
#(
  parameter int RES_BITS = 10,  // result width
  parameter int INSTR_CLKS = 4  // system clocks per instruction cycle
) (
  input  wire logic       clk_i,         // system clock
  input  wire logic       rst_i,         // synchronous reset
  input  wire logic [4:0] wb_adr_i,      // byte address
  input  wire logic [31:0] wb_dat_i,     // write data
  input  wire logic [3:0] wb_sel_i,      // byte enables
  input  wire logic       wb_we_i,       // write
  input  wire logic       wb_cyc_i,      // cycle
  input  wire logic       wb_stb_i,      // strobe
  output logic [31:0]     wb_dat_o,      // read data
  output logic            wb_ack_o,      // acknowledge
  input  wire logic       sleep_i,       // device sleeping
  input  wire logic       rc_tick_i,     // one pulse per rc clock period
  input  wire logic       comp_i,        // comparator: input above dac
  output logic [2:0]      channel_select_o, // mux channel
  output logic            vref_pos_ext_o,   // positive ref from pin
  output logic            vref_neg_ext_o,   // negative ref from pin
  output logic            powered_o,        // analog powered
  output logic            sample_o,         // sample-and-hold tracking
  output logic [9:0]      dac_o,            // trial code to comparator
  output logic            irq_o,            // converter interrupt
  output logic            wake_o            // wake request
);
  // ****************************************
  // register state
  // ****************************************
  logic [7:0]  ctrl_a_reg, ctrl_a_next;  // control a
  logic [2:0]  cks_reg, cks_next;        // clock select
  logic [9:0]  result_reg, result_next;  // stored result
  logic        done_reg, done_next;      // conv_done_flag
  logic        irqen_reg, irqen_next;    // conv_irq_enable
  logic        ack_reg, ack_next;        // bus ack
  logic [31:0] rdat_reg, rdat_next;      // read data
  logic        off_reg, off_next;        // powered down by sleep
  sar_state_t  st_reg, st_next;          // sequencer state
  logic [5:0]  div_reg, div_next;        // divider count
  logic [3:0]  per_reg, per_next;        // periods left
  logic [9:0]  sar_reg, sar_next;        // approximation register
  logic [9:0]  bit_reg, bit_next;        // current trial bit

  logic        rc_sel;      // rc clock chosen
  logic        tick;        // end of bit period
  logic        wr, rd_ok;   // bus strobes
  logic [5:0]  div_max;     // divider terminal count
  logic [7:0]  res_hi, res_lo;

  // ****************************************
  // helper functions
  // ****************************************
  // terminal count of system-clock divider
  function automatic logic [5:0] div_last(input logic [2:0] s);
    case (s)
      3'h0:    div_last = 6'h01;
      3'h4:    div_last = 6'h03;
      3'h1:    div_last = 6'h07;
      3'h5:    div_last = 6'h0f;
      3'h2:    div_last = 6'h1f;
      3'h6:    div_last = 6'h3f;
      default: div_last = 6'h01;
    endcase
  endfunction : div_last

  // result pair from justify bit
  function automatic logic [15:0] justify(input logic r, input logic [9:0] v);
    if (r) begin
      justify = {6'h00, v};
    end else begin
      justify = {v, 6'h00};
    end
  endfunction : justify

  // x11 in the clock field picks the rc clock
  assign rc_sel  = (cks_reg[1:0] == RC_SEL_LSBS[1:0]);
  assign div_max = div_last(cks_reg);
  assign tick    = rc_sel ? rc_tick_i : (div_reg == div_max);
  // writes land on the edge that samples ack high, not before
  assign wr      = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
  assign rd_ok   = wb_cyc_i && wb_stb_i && !ack_reg;
  assign {res_hi, res_lo} = justify(ctrl_a_reg[BIT_JUSTIFY], result_reg);

  // ****************************************
  // sequencer next state
  // ****************************************
  always_comb begin
    st_next  = st_reg;
    div_next = tick ? 6'h00 : 6'(div_reg + 6'h01);
    per_next = per_reg;
    sar_next = sar_reg;
    bit_next = bit_reg;
    off_next = off_reg;
    result_next = result_reg;
    done_next   = done_reg;
    ctrl_a_next = ctrl_a_reg;
    cks_next    = cks_reg;
    irqen_next  = irqen_reg;
    // register writes
    if (wr) begin
      case (wb_adr_i)
        {1'b0, OFS_CTRL_A}: ctrl_a_next = wb_dat_i[7:0];
        {1'b0, OFS_CTRL_B}: cks_next = wb_dat_i[BIT_CKS_LO +: 3];
        OFS_IRQ: begin
          done_next  = wb_dat_i[BIT_DONE];
          irqen_next = wb_dat_i[BIT_IRQEN];
        end
        default: ;
      endcase
    end
    // go only rises when already enabled
    if (wr && wb_adr_i == {1'b0, OFS_CTRL_A} && wb_dat_i[BIT_GO] && !ctrl_a_reg[BIT_ENABLE])
      ctrl_a_next[BIT_GO] = 1'b0;
    if (!ctrl_a_next[BIT_ENABLE]) off_next = 1'b0;
    case (st_reg)
      ST_IDLE, ST_ACQ: begin
        if (ctrl_a_reg[BIT_GO] && ctrl_a_reg[BIT_ENABLE] && !off_reg) begin
          st_next  = rc_sel ? ST_DELAY : ST_CONV;
          per_next = rc_sel ? 4'(INSTR_CLKS) : 4'(BITS_PER_CONV);
          div_next = 6'h00;
          sar_next = 10'h000;
          bit_next = 10'h200;
        end
      end
      ST_DELAY: begin
        per_next = 4'(per_reg - 4'h1);
        if (per_reg == 4'h1) begin
          st_next  = ST_CONV;
          per_next = 4'(BITS_PER_CONV);
        end
      end
      ST_CONV: begin
        // a run whose go was cleared is left to the abort path
        if (tick && ctrl_a_reg[BIT_GO]) begin
          per_next = 4'(per_reg - 4'h1);
          if (per_reg != 4'(BITS_PER_CONV)) begin // first period samples
            sar_next = comp_i ? (sar_reg | bit_reg) : sar_reg;
            bit_next = bit_reg >> 1;
          end
          if (per_reg == 4'h1) begin
            st_next = ST_IDLE;
            result_next = comp_i ? (sar_reg | bit_reg) : sar_reg;
            done_next = 1'b1;
            ctrl_a_next[BIT_GO] = 1'b0;
            if (sleep_i && !irqen_reg) off_next = 1'b1;
          end
        end
      end
      ST_ABORT: begin
        if (tick) begin
          per_next = 4'(per_reg - 4'h1);
          if (per_reg == 4'h1) st_next = ST_ACQ;
        end
      end
      default: st_next = ST_IDLE;
    endcase
    // abort paths, result untouched
    if ((st_reg == ST_CONV || st_reg == ST_DELAY) && !ctrl_a_reg[BIT_GO]) begin
      st_next  = ST_ABORT;
      per_next = 4'(ABORT_PERIODS);
      // restart the divider so the wait is two whole periods on a divided clock; the rc tick keeps its own phase
      div_next = 6'h00;
    end
    if (st_reg != ST_IDLE && st_reg != ST_ACQ && sleep_i && !rc_sel) begin
      st_next = ST_IDLE;
      off_next = 1'b1;
      ctrl_a_next[BIT_GO] = 1'b0;
    end
    if (!ctrl_a_reg[BIT_ENABLE]) begin
      st_next = ST_IDLE;
      ctrl_a_next[BIT_GO] = 1'b0;
    end
  end

  // ****************************************
  // bus read and ack
  // ****************************************
  always_comb begin
    ack_next  = rd_ok;
    // ack is a one-cycle pulse; a held strobe gets another one every second cycle
    rdat_next = 32'h0000_0000;
    case (wb_adr_i)
      {1'b0, OFS_CTRL_A}:   rdat_next = {24'h000000, ctrl_a_reg};
      {1'b0, OFS_CTRL_B}:   rdat_next = {25'h0000000, cks_reg, 4'h0};
      {1'b0, OFS_RES_HIGH}: rdat_next = {24'h000000, res_hi};
      {1'b0, OFS_RES_LOW}:  rdat_next = {24'h000000, res_lo};
      OFS_IRQ:              rdat_next = {30'h00000000, irqen_reg, done_reg};
      default:              rdat_next = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_a_reg <= CTRL_A_RST;
      cks_reg    <= CKS_RST;
      result_reg <= 10'h000;
      done_reg   <= 1'b0;
      irqen_reg  <= 1'b0;
      ack_reg    <= 1'b0;
      rdat_reg   <= 32'h0000_0000;
      off_reg    <= 1'b0;
      st_reg     <= ST_IDLE;
      div_reg    <= 6'h00;
      per_reg    <= 4'h0;
      sar_reg    <= 10'h000;
      bit_reg    <= 10'h000;
    end else begin
      ctrl_a_reg <= ctrl_a_next;
      cks_reg    <= cks_next;
      result_reg <= result_next;
      done_reg   <= done_next;
      irqen_reg  <= irqen_next;
      ack_reg    <= ack_next;
      rdat_reg   <= rdat_next;
      off_reg    <= off_next;
      st_reg     <= st_next;
      div_reg    <= div_next;
      per_reg    <= per_next;
      sar_reg    <= sar_next;
      bit_reg    <= bit_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign wb_ack_o         = ack_reg;
  assign wb_dat_o         = rdat_reg;
  assign channel_select_o = ctrl_a_reg[BIT_CHS_LO +: 3];
  assign vref_pos_ext_o   = ctrl_a_reg[BIT_VREFP];
  assign vref_neg_ext_o   = ctrl_a_reg[BIT_VREFN];
  assign powered_o        = ctrl_a_reg[BIT_ENABLE] && !off_reg;
  assign sample_o         = powered_o && (st_reg == ST_IDLE || st_reg == ST_ACQ ||
                            (st_reg == ST_CONV && per_reg == 4'(BITS_PER_CONV)));
  assign dac_o            = sar_reg | bit_reg;
  assign irq_o            = done_reg && irqen_reg;
  assign wake_o           = irq_o && sleep_i;

  // ****************************************
  // checks
  // ****************************************
  // a full run ending with go still set
  sequence conv_end_s;
    st_reg == ST_CONV && tick && per_reg == 4'h1 && ctrl_a_reg[BIT_GO] && !sleep_i;
  endsequence
  // flag set whatever the interrupt enable
  done_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_end_s ##0 ctrl_a_reg[BIT_ENABLE] |=> done_reg) else $error("flag not set");
  // hardware drops go on completion
  go_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_end_s ##0 ctrl_a_reg[BIT_ENABLE] |=> !ctrl_a_reg[BIT_GO]) else $error("go stuck");
  // abort never touches the stored result
  abort_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == ST_ABORT |-> $stable(result_reg)) else $error("result changed");
  // no acquisition in the first two cycles of the abort wait
  abort_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st_reg == ST_ABORT) |-> st_reg != ST_ACQ [*2]) else $error("early acq");
  // disabled converter stays idle
  off_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl_a_reg[BIT_ENABLE] |=> st_reg == ST_IDLE) else $error("runs while off");
  // completion raises the request while it is enabled
  irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_end_s ##0 ctrl_a_reg[BIT_ENABLE] ##1 irqen_reg |-> irq_o) else $error("irq wrong");
  // rc start goes through the extra delay
  rc_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == ST_IDLE && ctrl_a_reg[BIT_GO] && ctrl_a_reg[BIT_ENABLE] && !off_reg && rc_sel
    |=> st_reg == ST_DELAY) else $error("no rc delay");
  // go only falls by a bus write while converting
  busy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == ST_CONV |-> ctrl_a_reg[BIT_GO] || $past(wr)) else $error("go dropped");
  // sleep during a conversion on a divided clock powers the converter down
  sleep_abort_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st_reg == ST_CONV && sleep_i && !rc_sel |=> !powered_o) else $error("sleep no off");
endmodule : sar_adc_seq
`default_nettype wire

// ==== verilog/sar_pkg.sv ====
// ****************************************
// sequencer constants
// ****************************************
package sar_pkg;
  // register byte offsets
  localparam logic [3:0] OFS_CTRL_A     = 4'h0;  // converter_control_a
  localparam logic [3:0] OFS_CTRL_B     = 4'h4;  // converter_control_b
  localparam logic [3:0] OFS_RES_HIGH   = 4'h8;  // result_high_byte
  localparam logic [3:0] OFS_RES_LOW    = 4'hc;  // result_low_byte
  localparam logic [4:0] OFS_IRQ        = 5'h10; // flag and enable bits
  // converter_control_a fields
  localparam int BIT_JUSTIFY = 7;
  localparam int BIT_VREFN   = 6;
  localparam int BIT_VREFP   = 5;
  localparam int BIT_CHS_LO  = 2;
  localparam int BIT_GO      = 1;
  localparam int BIT_ENABLE  = 0;
  // converter_control_b field
  localparam int BIT_CKS_LO  = 4;
  // irq register fields
  localparam int BIT_DONE    = 0;
  localparam int BIT_IRQEN   = 1;
  // reset values
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [2:0] CKS_RST    = 3'h0;
  // conversion timing
  localparam int BITS_PER_CONV  = 11;
  localparam int ABORT_PERIODS  = 2;
  localparam int RC_START_DELAY = 1;
  localparam logic [2:0] RC_SEL_LSBS = 3'h3;
  // sequencer states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_DELAY = 5'b00010,
    ST_CONV  = 5'b00100,
    ST_ABORT = 5'b01000,
    ST_ACQ   = 5'b10000
  } sar_state_t;
endpackage : sar_pkg

// ==== tb/sar_cmp_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// sample-and-hold and comparator model
// ****************************************
module sar_cmp_model (
  input  wire logic       clk_i,    // system clock
  input  wire logic       sample_i, // tracking level
  input  wire logic [9:0] dac_i,    // trial code
  input  wire logic [9:0] vin_i,    // analog level as a code
  output logic            comp_o    // input above trial code
);
  logic [9:0] held_reg; // held sample
  // track while sampling, hold while converting
  always_ff @(posedge clk_i) begin
    if (sample_i) begin
      held_reg <= vin_i;
    end
  end
  // level sits half a step above its code, so no tie case
  assign comp_o = (dac_i <= held_reg);
endmodule : sar_cmp_model
`default_nettype wire

// ==== tb/sar_adc_sequencer_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module sar_adc_sequencer_tb;
  import sar_pkg::*;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0;
  logic sleep_i = 0, rc_tick_i = 0, comp_i, wb_ack_o, irq_o, wake_o;
  logic vref_pos_ext_o, vref_neg_ext_o, powered_o, sample_o;
  logic [4:0]  wb_adr_i = 5'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [3:0]  wb_sel_i = 4'h1;
  logic [2:0]  channel_select_o;
  logic [9:0]  dac_o, vin = 10'h000;
  logic [7:0]  q;
  int err_count = 0, checks = 0, cyc = 0;
  always #25 clk_i = ~clk_i;
  // cycle count and free rc oscillator, one tick per 10 clocks
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    rc_tick_i <= (cyc % 10 == 9);
  end
  sar_adc_seq dut_u (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .sleep_i, .rc_tick_i, .comp_i, .channel_select_o,
    .vref_pos_ext_o, .vref_neg_ext_o, .powered_o, .sample_o, .dac_o, .irq_o, .wake_o);
  sar_cmp_model cmp_u (.clk_i(clk_i), .sample_i(sample_o), .dac_i(dac_o), .vin_i(vin),
    .comp_o(comp_i));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic [4:0] a, input logic we, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_we_i <= we;
    wb_dat_i <= {24'h0, d};
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) begin
      chk("ack", 1, 0);
      stop_test();
    end
  endtask : wb
  // enable first, then go; poll go; judge time, result and flag
  task automatic conv(input logic [2:0] cks, input logic jf, input int per, input int rc);
    int t0, n, lo;
    wb(5'(OFS_CTRL_B), 1, {1'b0, cks, 4'h0});
    wb(5'(OFS_CTRL_A), 1, {jf, 7'h75});
    repeat (4) @(posedge clk_i);
    chk("chan", 5, channel_select_o);
    chk("refs", 3, {vref_neg_ext_o, vref_pos_ext_o});
    wb(5'(OFS_CTRL_A), 1, {jf, 7'h77});
    t0 = cyc;
    wb(5'(OFS_CTRL_A), 0, 8'h00);
    chk("busy", 1, q[BIT_GO]);
    n = 0;
    while (q[BIT_GO] === 1'b1 && n < 400) begin
      wb(5'(OFS_CTRL_A), 0, 8'h00);
      n++;
    end
    if (n >= 400) begin
      chk("poll", 0, 1);
      stop_test();
    end
    t0 = cyc - t0;
    // the first rc period may be partial, the free oscillator has its own phase
    lo = (rc > 0) ? 10 * per + rc - 2 : 11 * per - 2;
    chk("cycles", (t0 >= lo && t0 <= 12 * per + 12) ? t0 : lo, t0);
    wb(5'(OFS_RES_HIGH), 0, 8'h00);
    chk("res hi", jf ? {6'h0, vin[9:8]} : vin[9:2], q);
    wb(5'(OFS_RES_LOW), 0, 8'h00);
    chk("res lo", jf ? vin[7:0] : {vin[1:0], 6'h0}, q);
    wb(OFS_IRQ, 0, 8'h00);
    chk("done", 1, q[BIT_DONE]);
  endtask : conv
  // ****************************************
  // scenarios
  // ****************************************
  logic [2:0] sels [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
  int pers [8] = '{2, 4, 8, 16, 32, 64, 10, 10};
  localparam int INSTR_CLK_RC = 4; // rc start delay in clocks
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(5'(OFS_CTRL_A), 0, 8'h00);
    chk("ctrl a rst", CTRL_A_RST, q);
    wb(5'h14, 1, 8'hff);
    wb(5'h14, 0, 8'h00);
    chk("unmapped", 0, q);
    wb(5'(OFS_CTRL_A), 1, 8'h02); // go while disabled is dropped
    wb(5'(OFS_CTRL_A), 0, 8'h00);
    chk("go off", 0, {powered_o, q});
    for (int i = 0; i < 8; i++) begin
      vin = 10'h2a5 + 10'(i * 77);
      conv(sels[i], i[0], pers[i], (i > 5) ? INSTR_CLK_RC : 0);
      wb(OFS_IRQ, 1, 8'h00); // software clear
    end
    vin = 10'h1c3;
    conv(3'h0, 1'b1, 2, 0);
    wb(OFS_IRQ, 1, 8'h03);
    @(posedge clk_i);
    chk("irq", 1, irq_o);
    sleep_i <= 1'b1;
    @(posedge clk_i);
    @(posedge clk_i);
    chk("wake", 1, wake_o);
    sleep_i <= 1'b0;
    wb(OFS_IRQ, 1, 8'h02);
    @(posedge clk_i);
    chk("irq clr", 0, irq_o);
    wb(5'(OFS_CTRL_B), 1, 8'h30); // rc clock lets it run asleep
    wb(5'(OFS_CTRL_A), 1, 8'hf7);
    sleep_i <= 1'b1;
    repeat (150) @(posedge clk_i);
    chk("rc wake", 3, {wake_o, powered_o});
    sleep_i <= 1'b0;
    wb(OFS_IRQ, 1, 8'h02);
    vin = 10'h055;
    wb(5'(OFS_CTRL_B), 1, 8'h60);
    wb(5'(OFS_CTRL_A), 1, 8'hf7);
    repeat (200) @(posedge clk_i);
    wb(5'(OFS_CTRL_A), 1, 8'hf5); // abort mid-conversion
    repeat (100) @(posedge clk_i);
    chk("abort gap", 0, sample_o);
    repeat (60) @(posedge clk_i);
    chk("acquire", 1, sample_o);
    wb(5'(OFS_RES_LOW), 0, 8'h00);
    chk("res kept", 8'hc3, q);
    wb(5'(OFS_CTRL_A), 1, 8'hf7);
    repeat (100) @(posedge clk_i);
    sleep_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    wb(5'(OFS_CTRL_A), 0, 8'h00);
    chk("sleep off", 1, {powered_o, q[BIT_ENABLE]});
    sleep_i <= 1'b0;
    wb(5'(OFS_CTRL_A), 1, 8'hf4); // enable low clears the sleep-off state
    wb(5'(OFS_CTRL_A), 1, 8'hf5);
    wb(5'(OFS_CTRL_A), 1, 8'hf7);
    repeat (100) @(posedge clk_i);
    chk("running", 2, {powered_o, sample_o});
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    wb(5'(OFS_CTRL_A), 0, 8'h00);
    chk("mid reset", 0, {powered_o, q});
    stop_test();
  end
endmodule : sar_adc_sequencer_tb
`default_nettype wire
